//--- core/hdfc_pkg.sv
// Shared constants, register map and carrier types of the differential frame coder
package hdfc_pkg;
	// ************************************************************
	// Widths and sizes
	// ************************************************************
	localparam int DATA_W     = 16;
	localparam int FIFO_DEPTH = 32;
	localparam int REF_SIDE   = 16;
	localparam int REF_AW     = 8;
	localparam int ADDR_W     = 12;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_MARKER = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_REFDIM = 12'h00c;
	localparam logic [11:0] OFS_COUNT  = 12'h010;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int CTRL_ENCODE   = 0;
	localparam int CTRL_LOSSLESS = 1;
	localparam int CTRL_DIFF     = 2;
	localparam int CTRL_PREC_LSB = 4;
	localparam int CTRL_PT_LSB   = 8;
	localparam int CTRL_PSV_LSB  = 12;
	localparam int MARK_EH       = 8;
	localparam int MARK_EV       = 9;
	localparam int DIM_H_LSB     = 8;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0080;
	localparam logic [4:0]  REF_DIM_RESET = 5'h08;

	// ************************************************************
	// Marker codes
	// ************************************************************
	localparam logic [7:0] MK_SOI  = 8'hd8;
	localparam logic [7:0] MK_EOI  = 8'hd9;
	localparam logic [7:0] MK_DHP  = 8'hde;
	localparam logic [7:0] MK_EXP  = 8'hdf;
	localparam logic [7:0] MK_DHT  = 8'hc4;
	localparam logic [7:0] MK_JPG  = 8'hc8;
	localparam logic [7:0] MK_DAC  = 8'hcc;
	localparam logic [3:0] MK_SOF_HI = 4'hc;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {KIND_SAMPLE, KIND_DC, KIND_AC, KIND_DIFF} hdfc_kind_t;
	typedef enum logic [2:0] {ST_IDLE, ST_INTERP, ST_FRAME, ST_UPH, ST_UPV} hdfc_state_t;

	typedef struct packed {
		hdfc_kind_t        kind;
		logic [DATA_W-1:0] data;
	} hdfc_in_t;

	typedef struct packed {
		hdfc_kind_t        kind;
		logic [3:0]        category;
		logic [DATA_W-1:0] data;
	} hdfc_out_t;

	localparam int IN_W = $bits(hdfc_in_t);
endpackage

//--- core/hdfc_fifo.sv
// Synchronous valid/ready FIFO with registered full and empty flags
module hdfc_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 32
) (
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic             wrValid,
	output logic                  wrReady,
	input  wire logic [WIDTH-1:0] wrData,
	output logic                  rdValid,
	input  wire logic             rdReady,
	output logic      [WIDTH-1:0] rdData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_reg;
	logic [AW-1:0]    rdPtr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             push;
	logic             pop;

	assign push    = wrValid && wrReady;
	assign pop     = rdValid && rdReady;
	assign rdData  = mem[rdPtr_reg];

	always_comb begin
		count_next = count_reg;
		if (push && !pop)
			count_next = count_reg + 1'b1;
		else if (pop && !push)
			count_next = count_reg - 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (push)
			mem[wrPtr_reg] <= wrData;
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
			wrReady   <= 1'b0;
			rdValid   <= 1'b0;
		end else begin
			if (push)
				wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
			if (pop)
				rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
			count_reg <= count_next;
			wrReady   <= (count_next != (AW + 1)'(DEPTH));
			rdValid   <= (count_next != '0);
		end
	end
endmodule

//--- core/hdfc_core.sv
// Differential frame coding model, marker interpreter and reference upsampler
// Function
// - Encoder feeds differential samples to forward transform without level shift.
// - Encoder codes differential DC coefficient directly, no previous-block prediction.
// - Encoder codes lossless differences directly; scan predictor field forced to zero.
// - Amplitude category 15 covers magnitudes 16384 to 32767, either sign.
// - Decoder interprets markers before a frame until frame start or image end.
// - Hierarchy marker before first frame sets flag selecting hierarchical path.
// - Differential frame start takes differential path; upsample first if expansion pending.
// - Decoded differences add to reference modulo 65536; result becomes new reference.
// - Decoder inverse transform output for differential frames skips level shift.
// - Decoder takes differential DC value directly, without prediction.
// - Decoder outputs lossless differences directly, applying nonzero point transform.
// - Differential frames reuse ordinary frame, scan, restart and unit sequencing.
// - Arithmetic entropy path stays unchanged for differential frames.
// - Interpolated sample is sum of two neighbours halved with truncation.
// - Horizontal doubling runs before vertical doubling.
// - Right column and bottom line are replicated for edge interpolation.
//
// Implementation choices: the placing of the registers and the APB register port.
module hdfc_core
	import hdfc_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic      [31:0]       prdata,
	output logic                   pslverr,
	input  wire logic              inValid,
	output logic                   inReady,
	input  wire hdfc_in_t          inData,
	output logic                   outValid,
	input  wire logic              outReady,
	output hdfc_out_t              outData
);
	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [3:0] ampCat(input logic [DATA_W-1:0] v);
		logic [DATA_W:0] mag;
		logic [4:0]      cat;
		mag = v[DATA_W-1] ? ((DATA_W + 1)'(0) - {v[DATA_W-1], v}) : {1'b0, v};
		cat = 5'h00;
		for (int i = 0; i < DATA_W; i++) begin
			if (mag[i])
				cat = 5'(i + 1);
		end
		// The most negative code has no legal magnitude; it is held in the top class
		return (cat > 5'h0f) ? 4'hf : cat[3:0];
	endfunction

	function automatic logic [DATA_W-1:0] halfSum(input logic [DATA_W-1:0] a,
	                                              input logic [DATA_W-1:0] b);
		logic [DATA_W:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[DATA_W:1];
	endfunction

	function automatic logic [REF_AW-1:0] refAddr(input logic [4:0] x, input logic [4:0] y);
		return {y[3:0], x[3:0]};
	endfunction

	function automatic logic isSof(input logic [7:0] code);
		return (code[7:4] == MK_SOF_HI) && (code != MK_DHT) && (code != MK_JPG)
			&& (code != MK_DAC);
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	hdfc_state_t       state_reg;
	logic [31:0]       ctrl_reg;
	logic [9:0]        marker_reg;
	logic [4:0]        refW_reg;
	logic [4:0]        refH_reg;
	logic [31:0]       count_reg;
	logic              hierFlag_reg;
	logic              firstFrame_reg;
	logic              expPend_reg;
	logic              expH_reg;
	logic              expV_reg;
	logic              frameDiff_reg;
	logic [DATA_W-1:0] dcPred_reg;
	logic [DATA_W-1:0] prevSample_reg;
	logic [4:0]        posX_reg;
	logic [4:0]        posY_reg;
	logic [4:0]        upA_reg;
	logic [4:0]        upB_reg;
	logic              upPhase_reg;
	logic [DATA_W-1:0] upLo_reg;
	logic [DATA_W-1:0] upHi_reg;
	logic [DATA_W-1:0] refMem [REF_SIDE * REF_SIDE];

	logic              fifoValid;
	logic              fifoReady;
	hdfc_in_t          fifoData;
	logic [IN_W-1:0]   fifoRaw;

	logic              setup;
	logic              wrMarker;
	logic [7:0]        mCode;
	logic              encode;
	logic              diffMode;
	logic              procEn;
	logic              take;
	logic              spatial;
	logic [3:0]        precision;
	logic [3:0]        pointTf;
	logic [DATA_W-1:0] levelShift;
	logic [DATA_W-1:0] refSample;
	logic [DATA_W-1:0] result;
	logic [2:0]        predField;
	logic              upLast;

	assign setup      = psel && !penable;
	assign wrMarker   = setup && pwrite && (paddr == OFS_MARKER);
	assign mCode      = pwdata[7:0];
	assign encode     = ctrl_reg[CTRL_ENCODE];
	assign precision  = ctrl_reg[CTRL_PREC_LSB +: 4];
	assign pointTf    = ctrl_reg[CTRL_PT_LSB +: 4];
	assign levelShift = DATA_W'(17'h00001 << (precision - 4'h1));
	assign diffMode   = encode ? ctrl_reg[CTRL_DIFF] : frameDiff_reg;
	assign predField  = diffMode ? 3'h0 : ctrl_reg[CTRL_PSV_LSB +: 3];
	// Frames flow through the same unit sequencing whether differential or not
	assign procEn     = encode || (state_reg == ST_FRAME);
	assign fifoReady  = procEn && (!outValid || outReady);
	assign take       = fifoValid && fifoReady;
	assign fifoData   = hdfc_in_t'(fifoRaw);
	assign spatial    = (fifoData.kind == KIND_SAMPLE) || (fifoData.kind == KIND_DIFF);
	assign refSample  = refMem[refAddr(posX_reg, posY_reg)];

	// Input samples queue here while the upsampler owns the reference store
	hdfc_fifo #(
		.WIDTH (IN_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.wrValid (inValid),
		.wrReady (inReady),
		.wrData  (inData),
		.rdValid (fifoValid),
		.rdReady (fifoReady),
		.rdData  (fifoRaw)
	);

	// ************************************************************
	// Coding model
	// ************************************************************
	// Entropy coding stages downstream see the same symbols either way;
	// the arithmetic path needs no change for differential frames.
	always_comb begin
		result = fifoData.data;
		if (encode) begin
			case (fifoData.kind)
				KIND_SAMPLE: result = diffMode ? fifoData.data
					: fifoData.data - levelShift;
				KIND_DC:     result = diffMode ? fifoData.data
					: fifoData.data - dcPred_reg;
				KIND_DIFF:   result = diffMode ? fifoData.data
					: fifoData.data - prevSample_reg;
				default:     result = fifoData.data;
			endcase
		end else begin
			case (fifoData.kind)
				KIND_SAMPLE: result = diffMode ? fifoData.data + refSample
					: fifoData.data + levelShift;
				KIND_DC:     result = diffMode ? fifoData.data
					: fifoData.data + dcPred_reg;
				KIND_DIFF:   result = diffMode ? (fifoData.data << pointTf) + refSample
					: fifoData.data + prevSample_reg;
				default:     result = fifoData.data;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			outValid <= 1'b0;
			outData  <= '0;
		end else if (take) begin
			outValid         <= 1'b1;
			outData.kind     <= fifoData.kind;
			outData.data     <= result;
			outData.category <= ampCat(result);
		end else if (outReady) begin
			outValid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dcPred_reg     <= '0;
			prevSample_reg <= '0;
			count_reg      <= '0;
		end else if (wrMarker && isSof(mCode)) begin
			dcPred_reg     <= '0;
			prevSample_reg <= '0;
			count_reg      <= '0;
		end else if (take) begin
			count_reg <= count_reg + 32'h1;
			if (fifoData.kind == KIND_DC)
				dcPred_reg <= encode ? fifoData.data : result;
			if (fifoData.kind == KIND_DIFF)
				prevSample_reg <= encode ? fifoData.data : result;
		end
	end

	// Raster position into the reference store
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			posX_reg <= '0;
			posY_reg <= '0;
		end else if (wrMarker && isSof(mCode)) begin
			posX_reg <= '0;
			posY_reg <= '0;
		end else if (take && spatial) begin
			if (posX_reg + 5'h01 >= refW_reg) begin
				posX_reg <= '0;
				posY_reg <= (posY_reg + 5'h01 >= refH_reg) ? 5'h00 : posY_reg + 5'h01;
			end else begin
				posX_reg <= posX_reg + 5'h01;
			end
		end
	end

	// ************************************************************
	// Marker interpreter
	// ************************************************************
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg      <= ST_IDLE;
			hierFlag_reg   <= 1'b0;
			firstFrame_reg <= 1'b0;
			expPend_reg    <= 1'b0;
			expH_reg       <= 1'b0;
			expV_reg       <= 1'b0;
			frameDiff_reg  <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (wrMarker && (mCode == MK_SOI)) begin
						state_reg      <= ST_INTERP;
						hierFlag_reg   <= 1'b0;
						firstFrame_reg <= 1'b0;
						expPend_reg    <= 1'b0;
					end
				end
				ST_INTERP, ST_FRAME: begin
					if (wrMarker) begin
						// Anything but frame start or image end keeps us interpreting
						state_reg <= ST_INTERP;
						if (mCode == MK_EOI) begin
							state_reg <= ST_IDLE;
						end else if (mCode == MK_SOI) begin
							hierFlag_reg   <= 1'b0;
							firstFrame_reg <= 1'b0;
							expPend_reg    <= 1'b0;
						end else if (mCode == MK_DHP && !firstFrame_reg) begin
							hierFlag_reg <= 1'b1;
						end else if (mCode == MK_EXP) begin
							expPend_reg <= 1'b1;
							expH_reg    <= pwdata[MARK_EH];
							expV_reg    <= pwdata[MARK_EV];
						end else if (isSof(mCode)) begin
							firstFrame_reg <= 1'b1;
							frameDiff_reg  <= hierFlag_reg && mCode[2] && (mCode[1:0] != 2'b00);
							state_reg      <= ST_FRAME;
							if (hierFlag_reg && mCode[2] && (mCode[1:0] != 2'b00) && expPend_reg)
								state_reg <= expH_reg ? ST_UPH : ST_UPV;
						end
					end
				end
				ST_UPH: begin
					if (upLast)
						state_reg <= expV_reg ? ST_UPV : ST_FRAME;
				end
				ST_UPV: begin
					if (upLast) begin
						state_reg   <= ST_FRAME;
						expPend_reg <= 1'b0;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
			if (state_reg == ST_UPH && upLast && !expV_reg)
				expPend_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Reference upsampler
	// ************************************************************
	// Works in place from the far end backwards so no source sample is
	// overwritten before both of its reads; two cycles per source sample.
	assign upLast = upPhase_reg && (upA_reg == 5'h00)
		&& (upB_reg + 5'h01 >= ((state_reg == ST_UPH) ? refH_reg : refW_reg));

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			upA_reg     <= '0;
			upB_reg     <= '0;
			upPhase_reg <= 1'b0;
			upLo_reg    <= '0;
			upHi_reg    <= '0;
		end else if (state_reg == ST_UPH || state_reg == ST_UPV) begin
			upPhase_reg <= !upPhase_reg;
			if (!upPhase_reg) begin
				upLo_reg <= (state_reg == ST_UPH) ? refMem[refAddr(upA_reg, upB_reg)]
					: refMem[refAddr(upB_reg, upA_reg)];
				upHi_reg <= (state_reg == ST_UPH)
					? refMem[refAddr((upA_reg + 5'h01 >= refW_reg) ? upA_reg
						: upA_reg + 5'h01, upB_reg)]
					: refMem[refAddr(upB_reg, (upA_reg + 5'h01 >= refH_reg) ? upA_reg
						: upA_reg + 5'h01)];
			end else if (upA_reg != 5'h00) begin
				upA_reg <= upA_reg - 5'h01;
			end else begin
				upB_reg <= upB_reg + 5'h01;
				upA_reg <= ((state_reg == ST_UPH) ? refW_reg : refH_reg) - 5'h01;
				if (upLast) begin
					upB_reg <= '0;
					upA_reg <= refH_reg - 5'h01;
				end
			end
		end else begin
			upPhase_reg <= 1'b0;
			upB_reg     <= '0;
			upA_reg     <= (expH_reg ? refW_reg : refH_reg) - 5'h01;
		end
	end

	// Single writer of the reference store: upsampler or reconstruction
	always_ff @(posedge ref_clk) begin
		if (state_reg == ST_UPH) begin
			if (!upPhase_reg)
				refMem[refAddr({upA_reg[3:0], 1'b0}, upB_reg)] <=
					refMem[refAddr(upA_reg, upB_reg)];
			else
				refMem[refAddr({upA_reg[3:0], 1'b1}, upB_reg)] <=
					halfSum(upLo_reg, upHi_reg);
		end else if (state_reg == ST_UPV) begin
			if (!upPhase_reg)
				refMem[refAddr(upB_reg, {upA_reg[3:0], 1'b0})] <=
					refMem[refAddr(upB_reg, upA_reg)];
			else
				refMem[refAddr(upB_reg, {upA_reg[3:0], 1'b1})] <=
					halfSum(upLo_reg, upHi_reg);
		end else if (take && spatial && !encode) begin
			refMem[refAddr(posX_reg, posY_reg)] <= result;
		end
	end

	// ************************************************************
	// APB slave
	// ************************************************************
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg   <= CTRL_RESET;
			marker_reg <= '0;
			refW_reg   <= REF_DIM_RESET;
			refH_reg   <= REF_DIM_RESET;
		end else begin
			if (setup && pwrite && paddr == OFS_CTRL)
				ctrl_reg <= pwdata;
			if (wrMarker)
				marker_reg <= pwdata[9:0];
			// Dimensions double as each pass finishes; a software write in that same cycle loses
			if (state_reg == ST_UPH && upLast)
				refW_reg <= {refW_reg[3:0], 1'b0};
			else if (state_reg == ST_UPV && upLast)
				refH_reg <= {refH_reg[3:0], 1'b0};
			else if (setup && pwrite && paddr == OFS_REFDIM) begin
				refW_reg <= pwdata[4:0];
				refH_reg <= pwdata[DIM_H_LSB +: 5];
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (setup) begin
				case (paddr)
					OFS_CTRL:   prdata <= ctrl_reg;
					OFS_MARKER: prdata <= {22'h0, marker_reg};
					OFS_STATUS: prdata <= {20'h0, predField, frameDiff_reg, expV_reg,
						expH_reg, expPend_reg, hierFlag_reg, 1'b0, state_reg};
					OFS_REFDIM: prdata <= {19'h0, refH_reg, 3'h0, refW_reg};
					OFS_COUNT:  prdata <= count_reg;
					default:    pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule

//--- verification/hdfc_core_assertions.sv
// Port-level checker of the differential frame coder and its bind
module hdfc_core_chk
	import hdfc_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              sys_rst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic [31:0]       prdata,
	input wire logic              pslverr,
	input wire logic              inValid,
	input wire logic              inReady,
	input wire hdfc_in_t          inData,
	input wire logic              outValid,
	input wire logic              outReady,
	input wire hdfc_out_t         outData
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	setup_answer_a: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held two cycles");
	idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside access");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	unmapped_err_a: assert property (psel && !penable && paddr > OFS_COUNT |=> pslverr)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (psel && !penable && paddr[1:0] == 2'h0
		&& paddr <= OFS_COUNT |=> !pslverr) else $error("mapped access refused");
	out_hold_a: assert property (outValid && !outReady |=> outValid && $stable(outData))
		else $error("output changed while stalled");
	top_category_a: assert property (outValid && outData.kind == KIND_AC |->
		(outData.category == 4'hf) == ($signed(outData.data) >= 16384
		|| $signed(outData.data) <= -16384)) else $error("category 15 range wrong");
	psv_zero_a: assert property (pready && !pwrite && paddr == OFS_STATUS
		&& prdata[8] |-> prdata[11:9] == 3'h0) else $error("predictor field not zero");
endmodule

bind hdfc_core hdfc_core_chk u_hdfc_core_chk (.ref_clk, .sys_rst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .inValid, .inReady, .inData,
	.outValid, .outReady, .outData);

//--- verification/hdfc_sink.sv
// Downstream coding stage model that collects output words under back-pressure
module hdfc_sink
	import hdfc_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire logic      sys_rst,
	input  wire logic      outValid,
	input  wire hdfc_out_t outData,
	input  wire logic      stall,
	output logic           outReady
);
	timeunit 1ns;
	timeprecision 1ps;
	hdfc_out_t  got[$];
	logic [7:0] lfsr;

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			outReady <= 1'b0;
			lfsr <= 8'h5a;
		end else begin
			if (outValid && outReady)
				got.push_back(outData);
			lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
			// Stalls about half the cycles so the output hold is exercised
			outReady <= !stall || lfsr[0];
		end
	end
endmodule

//--- verification/hierarchical_differential_frame_coder_tb.sv
// Self-checking bench of the differential frame coder
module hierarchical_differential_frame_coder_tb;
	import hdfc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic              ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
	logic              inValid, inReady, outValid, outReady, stall, e, ok;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, r;
	logic [31:0]       seed = 32'h0000_000b;
	logic [15:0]       d, rm [16][16], q [64];
	logic [15:0]       cor [6] = '{16'h4000, 16'h7fff, 16'hc000, 16'h8000, 16'hbfff, 16'h3fff};
	logic [7:0]        sofs [6] = '{8'hc5, 8'hc6, 8'hc7, 8'hcd, 8'hce, 8'hcf};
	hdfc_in_t          inData;
	hdfc_out_t         outData, expQ[$];
	int                error_cnt, checks, w, h, n;

	hdfc_core u_hdfc_core (.ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .inValid, .inReady, .inData, .outValid, .outReady, .outData);
	hdfc_sink u_hdfc_sink (.ref_clk, .sys_rst, .outValid, .outData, .stall, .outReady);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction

	function automatic logic [3:0] catf(logic [15:0] v);
		logic [15:0] m;
		m = v[15] ? -v : v;
		for (int b = 15; b >= 0; b--)
			if (m[b])
				return b >= 14 ? 4'hf : 4'(b + 1);
		return 4'h0;
	endfunction

	function automatic logic [15:0] av(logic [15:0] a, logic [15:0] b);
		return 16'(({1'b0, a} + {1'b0, b}) >> 1);
	endfunction

	function automatic int mn(int a, int b);
		return a < b ? a : b;
	endfunction

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, x, s);
		end
	endtask

	// ************************************************************
	// Bus and stream drivers
	// ************************************************************
	task automatic rg(input logic wr, input logic [11:0] a, input logic [31:0] dd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] x);
		rg(1'b0, a, 32'h0);
		chk(nm, r & m, x);
	endtask

	task automatic mk(input logic [7:0] c, input logic eh, input logic ev);
		rg(1'b1, OFS_MARKER, {22'h0, ev, eh, c});
	endtask

	task automatic push(input hdfc_kind_t k, input logic [15:0] dd, input int lim);
		int i;
		inValid <= 1'b1;
		inData <= '{k, dd};
		i = 0;
		do begin
			@(posedge ref_clk);
			ok = inReady;
			i++;
		end while (ok !== 1'b1 && i < lim);
	endtask

	task automatic xp(input hdfc_kind_t k, input logic [15:0] dd);
		expQ.push_back('{k, catf(dd), dd});
	endtask

	task automatic drain(input int cnt);
		int i;
		hdfc_out_t g, x;
		inValid <= 1'b0;
		i = 0;
		while (u_hdfc_sink.got.size() < cnt && i < 20000) begin
			@(posedge ref_clk);
			i++;
		end
		chk("out count", u_hdfc_sink.got.size(), cnt);
		repeat (cnt) begin
			g = u_hdfc_sink.got.pop_front();
			x = expQ.pop_front();
			chk("out word", {g.kind, g.data}, {x.kind, x.data});
			if (x.kind == KIND_AC)
				chk("category", g.category, x.category);
		end
	endtask

	// Reference upsampling; even positions average a sample with itself
	task automatic up(input bit v);
		logic [15:0] t [16][16];
		for (int y = 0; y < 16; y++)
			for (int x = 0; x < 16; x++)
				t[y][x] = v ? av(rm[y/2][x], rm[mn(y/2 + y%2, h - 1)][x])
					: av(rm[y][x/2], rm[y][mn(x/2 + x%2, w - 1)]);
		rm = t;
	endtask

	task automatic test_done();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		test_done();
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{psel, penable, pwrite, inValid, stall} = '0;
		paddr = '0;
		pwdata = '0;
		inData = '0;
		sys_rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdc("ctrl reset", OFS_CTRL, 32'hffff_ffff, CTRL_RESET);
		rdc("dim reset", OFS_REFDIM, 32'h1f1f, 32'h0808);
		rdc("count reset", OFS_COUNT, 32'hffff_ffff, 32'h0);
		rg(1'b1, OFS_STATUS, 32'hffff_ffff);
		rdc("status ro", OFS_STATUS, 32'hffff_ffff, 32'h0);
		rg(1'b0, 12'h014, 32'h0);
		chk("unmapped err", e, 1'b1);
		chk("unmapped data", r, 32'h0);
		$display("test registers done");
		stall <= 1'b1;
		wr_ctrl: begin
			rg(1'b1, OFS_CTRL, 32'h0000_5085);
			rdc("ctrl rw", OFS_CTRL, 32'hffff_ffff, 32'h0000_5085);
			rdc("enc psv", OFS_STATUS, 32'h0000_0e00, 32'h0);
		end
		for (int i = 0; i < 40; i++) begin
			d = i < 6 ? cor[i] : rnd();
			push(i < 6 ? KIND_AC : hdfc_kind_t'(i % 4), d, 5000);
			xp(i < 6 ? KIND_AC : hdfc_kind_t'(i % 4), d);
		end
		drain(40);
		rg(1'b1, OFS_CTRL, 32'h0000_0081);
		for (int i = 0; i < 8; i++) begin
			d = rnd();
			push(KIND_SAMPLE, d, 5000);
			xp(KIND_SAMPLE, d - 16'h0080);
		end
		drain(8);
		$display("test encode done");
		rg(1'b1, OFS_CTRL, 32'h0000_0080);
		mk(MK_SOI, 1'b0, 1'b0);
		rdc("soi", OFS_STATUS, 32'h37, 32'h1);
		mk(MK_DHT, 1'b0, 1'b0);
		rdc("other marker", OFS_STATUS, 32'h7, 32'h1);
		mk(MK_DHP, 1'b0, 1'b0);
		rdc("hier flag", OFS_STATUS, 32'h17, 32'h11);
		w = 8;
		h = 8;
		for (int i = 0; i < 64; i++) begin
			q[i] = rnd() & 16'h007f;
			rm[i/8][i%8] = q[i] + 16'h0080;
			xp(KIND_SAMPLE, rm[i/8][i%8]);
		end
		// Outside a frame the decoder does not pop, so the buffer must fill
		n = 0;
		do begin
			push(KIND_SAMPLE, q[n], 4);
			if (ok === 1'b1)
				n++;
		end while (ok === 1'b1 && n < 64);
		inValid <= 1'b0;
		chk("fill level", n, FIFO_DEPTH);
		mk(8'hc0, 1'b0, 1'b0);
		rdc("plain sof", OFS_STATUS, 32'h107, 32'h2);
		for (int i = n; i < 64; i++)
			push(KIND_SAMPLE, q[i], 5000);
		drain(64);
		mk(MK_EXP, 1'b1, 1'b0);
		rdc("exp pending", OFS_STATUS, 32'h60, 32'h60);
		mk(8'hc5, 1'b0, 1'b0);
		up(1'b0);
		w = 16;
		for (int i = 0; i < 4; i++) begin
			d = rnd();
			push(KIND_DC, d, 5000);
			xp(KIND_DC, d);
		end
		for (int i = 0; i < 128; i++) begin
			d = rnd() & 16'h00ff;
			push(KIND_SAMPLE, d, 5000);
			rm[i/16][i%16] += d;
			xp(KIND_SAMPLE, rm[i/16][i%16]);
		end
		drain(132);
		rdc("dim h", OFS_REFDIM, 32'h1f1f, 32'h0810);
		rdc("exp cleared", OFS_STATUS, 32'h137, 32'h112);
		rg(1'b1, OFS_CTRL, 32'h0000_0180);
		mk(MK_EXP, 1'b0, 1'b1);
		mk(8'hce, 1'b0, 1'b0);
		up(1'b1);
		h = 16;
		for (int i = 0; i < 256; i++) begin
			d = rnd();
			push(hdfc_kind_t'(i % 2 * 3), d, 5000);
			rm[i/16][i%16] += d << i % 2;
			xp(hdfc_kind_t'(i % 2 * 3), rm[i/16][i%16]);
		end
		drain(256);
		rdc("cnt", OFS_COUNT, '1, 32'h100);
		rdc("dim v", OFS_REFDIM, 32'h1f1f, 32'h1010);
		$display("test decode done");
		foreach (sofs[i]) begin
			mk(MK_EOI, 1'b0, 1'b0);
			rdc("eoi idle", OFS_STATUS, 32'h7, 32'h0);
			mk(MK_SOI, 1'b0, 1'b0);
			rdc("hier clear", OFS_STATUS, 32'h37, 32'h1);
			mk(MK_DHP, 1'b0, 1'b0);
			mk(sofs[i], 1'b0, 1'b0);
			rdc("diff sof", OFS_STATUS, 32'h137, 32'h112);
		end
		$display("test markers done");
		test_done();
	end
endmodule
